//--- hdl/tsel_defs.vh
// Behaviour
// - Flag for inputs one to eight sets when its live validity bit toggles.
// - With soft alarms enabled, a toggle of the input soft alarm also sets it.
// - Writing 1 clears an input flag; only a new toggle sets it again.
// - Interrupt request is high while any set flag has its enable set.
// - Inputs nine to fourteen flag in bits 5..0 of flags B, same behaviour.
// - Bit 7 of flags B sets on primary PLL state change; write 1 clears.
// - Bit 6 of flags B sets on selected reference failure; write 1 clears.
// - Reference failure never sets in free-run or holdover.
// - Frequency high register shows frequency bits 18..16 in bits 2..0, rest zero.
// - Frame sync flag (C bit 7) sets only on rising alarm edge; write 1 clears.
// - C bit 6 sets when secondary PLL gains or loses lock; write 1 clears.
// - C bit 5 sets when phase limit is exceeded anew; write 1 clears.
// - C bit 4 sets on secondary no-input; clearing fails while it persists.
// - AMI violation: seven marks plus violation pattern broken in two consecutive periods.
// - With the 400 Hz tone detected, its missing violations are not errors.
// - Loss flag sets after 32 s without pulses; resets only on new loss.
// - AMI and loss flags act only while the format select is 0.
// - AMI flags in C bits 3 and 1, loss flags in bits 2 and 0.
// - Primary state code: 001,010,100,101,110,111; flag follows its changes.
`ifndef TSEL_DEFS_VH
`define TSEL_DEFS_VH

`define TSEL_ADDR_FLAGS_A 8'h05
`define TSEL_ADDR_FLAGS_B 8'h06
`define TSEL_ADDR_PLL_FREQUENCY_VALUE_HIGH 8'h07
`define TSEL_ADDR_FLAGS_C 8'h08
`define TSEL_ADDR_OP_STATE 8'h09

`define TSEL_RST_FLAGS_A 8'hFF
`define TSEL_RST_FLAGS_B 8'h3F
`define TSEL_RST_FLAGS_C 8'h50
`define TSEL_RDATA_IDLE 8'h00

`define TSEL_B_STATE 7
`define TSEL_B_SELECTED_REF_FAILED 6
`define TSEL_B_IN_MSB 5
`define TSEL_C_FRAME_SYNC_MONITOR_ALARM 7
`define TSEL_C_LOCK 6
`define TSEL_C_PHASE_MONITOR_ALARM 5
`define TSEL_C_NOIN 4
`define TSEL_C_BIPOLAR_VIOLATION_IN_TWO 3
`define TSEL_C_SIGNAL_LOSS_IN_TWO 2
`define TSEL_C_BIPOLAR_VIOLATION_IN_ONE 1
`define TSEL_C_SIGNAL_LOSS_IN_ONE 0

`define TSEL_OP_FRAME_SYNC_MONITOR_ALARM 7
`define TSEL_OP_LOCK 6
`define TSEL_OP_T0SOFT 5
`define TSEL_OP_T4SOFT 4
`define TSEL_OP_STATE_MSB 2

`define TSEL_PLL_FREQUENCY_VALUE_MSB 18
`define TSEL_PLL_FREQUENCY_VALUE_LSB 16

`define TSEL_ST_FREE_RUN 3'h1
`define TSEL_ST_HOLDOVER 3'h2
`define TSEL_ST_LOCKED 3'h4
`define TSEL_ST_PRELOCK2 3'h5
`define TSEL_ST_PRELOCK 3'h6
`define TSEL_ST_LOSS_LOCK 3'h7

`define TSEL_NUM_INPUTS 14
`define TSEL_NUM_LOW 8

`define TSEL_AMI_LAST_POS 3'h7
`define TSEL_AMI_BAD_RUN 2'h2
`define TSEL_LOS_TIME_S 32
`define TSEL_CLK_HZ 40000000

`endif

//--- hdl/tsel_sync.v
`timescale 1ns/100ps
`default_nettype none
module tsel_sync #(
  parameter WIDTH = 2
) (
  input wire clk, // System clock
  input wire [WIDTH-1:0] din, // Asynchronous levels
  output wire [WIDTH-1:0] dout // Synchronised levels
);
  reg [WIDTH-1:0] meta_r;
  reg [WIDTH-1:0] sync_r;

  // First stage feeds only the second
  always @(posedge clk) begin
    meta_r <= din;
    sync_r <= meta_r;
  end

  assign dout = sync_r;
endmodule // tsel_sync
`default_nettype wire

//--- hdl/tsel_cc_mon.v
`timescale 1ns/100ps
`default_nettype none
`include "tsel_defs.vh"
module tsel_cc_mon #(
  parameter [30:0] LOS_CYCLES = `TSEL_LOS_TIME_S * `TSEL_CLK_HZ
) (
  input wire clk, // System clock
  input wire rst, // Synchronous reset, high
  input wire pos_pin, // Positive mark pin
  input wire neg_pin, // Negative mark pin
  input wire tone_detect, // 400 Hz component present
  output reg ami_viol_r, // One-cycle AMI violation pulse
  output reg los_r // Live loss of signal level
);
  wire [1:0] pins_s;
  reg [1:0] pins_d_r;
  reg last_pol_r;
  reg [2:0] pos_cnt_r;
  reg bad_r;
  reg [1:0] bad_run_r;
  reg [30:0] idle_cnt_r;
  wire pos_mark;
  wire neg_mark;
  wire mark;
  wire bpv;
  wire at_end;
  wire err;
  wire period_bad;

  tsel_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .din({pos_pin, neg_pin}),
    .dout(pins_s)
  );

  assign pos_mark = pins_s[1] & ~pins_d_r[1];
  assign neg_mark = pins_s[0] & ~pins_d_r[0];
  assign mark = pos_mark | neg_mark;
  assign bpv = mark & (pos_mark == last_pol_r);
  assign at_end = (pos_cnt_r == `TSEL_AMI_LAST_POS);
  // Missing violation forgiven while the tone is present
  assign err = mark & ((bpv & ~at_end) | (~bpv & at_end & ~tone_detect));
  assign period_bad = bad_r | err;

  always @(posedge clk) begin
    if (rst) begin
      pins_d_r <= 2'h0;
      last_pol_r <= 1'b0;
      pos_cnt_r <= 3'h0;
      bad_r <= 1'b0;
      bad_run_r <= 2'h0;
      ami_viol_r <= 1'b0;
    end else begin
      pins_d_r <= pins_s;
      ami_viol_r <= 1'b0;
      if (mark) begin
        last_pol_r <= pos_mark;
        // A violation always closes the period so the framing realigns
        if (at_end | bpv) begin
          pos_cnt_r <= 3'h0;
          bad_r <= 1'b0;
          if (period_bad) begin
            if (bad_run_r == `TSEL_AMI_BAD_RUN - 2'h1) begin
              ami_viol_r <= 1'b1;
              bad_run_r <= 2'h0;
            end else begin
              bad_run_r <= bad_run_r + 2'h1;
            end
          end else begin
            bad_run_r <= 2'h0;
          end
        end else begin
          pos_cnt_r <= pos_cnt_r + 3'h1;
          bad_r <= period_bad;
        end
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      idle_cnt_r <= 31'h0;
      los_r <= 1'b0;
    end else if (mark) begin
      idle_cnt_r <= 31'h0;
      los_r <= 1'b0;
    end else if (idle_cnt_r == LOS_CYCLES - 31'h1) begin
      los_r <= 1'b1;
    end else begin
      idle_cnt_r <= idle_cnt_r + 31'h1;
    end
  end
endmodule // tsel_cc_mon
`default_nettype wire

//--- hdl/tsel_top.v
`timescale 1ns/100ps
`default_nettype none
`include "tsel_defs.vh"
module tsel_top #(
  parameter [30:0] LOS_CYCLES = `TSEL_LOS_TIME_S * `TSEL_CLK_HZ
) (
  input wire clk, // System clock, 40 MHz
  input wire rst, // Synchronous reset, high
  input wire [7:0] host_addr, // Register address
  input wire host_wr, // Write strobe, one cycle
  input wire host_rd, // Read strobe, one cycle
  input wire [7:0] host_wdata, // Write data
  output reg [7:0] host_rdata_r, // Read data, valid cycle after host_rd
  input wire [7:0] input_valid_live_low, // Live validity, inputs 1..8
  input wire [5:0] input_valid_live_high, // Live validity, inputs 9..14
  input wire [13:0] input_soft_alarm, // Live soft frequency alarms
  input wire soft_alarm_enable, // Soft alarms count as changes
  input wire [2:0] primary_pll_state_code, // Live primary PLL state
  input wire selected_ref_failed, // Pulse: no edge on selected reference
  input wire frame_sync_monitor_alarm, // Live frame sync alarm
  input wire secondary_pll_locked, // Live secondary PLL lock
  input wire primary_soft_alarm, // Live primary PLL soft alarm
  input wire secondary_soft_alarm, // Live secondary PLL soft alarm
  input wire phase_monitor_alarm, // Level: phase limit exceeded
  input wire secondary_pll_no_input, // Level: no valid secondary input
  input wire [18:0] pll_frequency_value, // Current PLL frequency
  input wire cc_one_pos, // Composite clock input one, positive
  input wire cc_one_neg, // Composite clock input one, negative
  input wire cc_two_pos, // Composite clock input two, positive
  input wire cc_two_neg, // Composite clock input two, negative
  input wire cc_one_tone, // 400 Hz tone detected on input one
  input wire cc_two_tone, // 400 Hz tone detected on input two
  input wire input_one_format_select, // 0: input one is composite clock
  input wire input_two_format_select, // 0: input two is composite clock
  input wire [7:0] irq_enable_a, // Enables for flags A
  input wire [7:0] irq_enable_b, // Enables for flags B
  input wire [7:0] irq_enable_c, // Enables for flags C
  output reg interrupt_request_pin // Interrupt request, high
);
  reg [7:0] flags_a_r;
  reg [7:0] flags_b_r;
  reg [7:0] flags_c_r;
  reg [7:0] flags_a_nxt;
  reg [7:0] flags_b_nxt;
  reg [7:0] flags_c_nxt;
  reg primed_r;
  reg [13:0] valid_d_r;
  reg [13:0] soft_d_r;
  reg [2:0] state_d_r;
  reg frame_sync_monitor_alarm_d_r;
  reg lock_d_r;
  reg phase_monitor_alarm_d_r;
  reg [1:0] los_d_r;
  reg [7:0] rdata_nxt;

  wire [13:0] valid_live;
  wire [13:0] input_change;
  wire wr_a;
  wire wr_b;
  wire wr_c;
  wire state_change;
  wire ref_fail_set;
  wire frame_sync_monitor_alarm_set;
  wire lock_set;
  wire phase_monitor_alarm_set;
  wire [1:0] ami_pulse;
  wire [1:0] los_live;
  wire [1:0] cc_enabled;
  wire [1:0] ami_set;
  wire [1:0] los_set;
  wire [7:0] op_state_view;
  wire [7:0] pll_frequency_value_high_view;
  wire irq_nxt;

  assign valid_live = {input_valid_live_high, input_valid_live_low};

  // Edge detectors are blind on the first cycle after reset so the
  // reset-time sampling of live levels cannot raise spurious flags.
  always @(posedge clk) begin
    valid_d_r <= valid_live;
    soft_d_r <= input_soft_alarm;
    state_d_r <= primary_pll_state_code;
    frame_sync_monitor_alarm_d_r <= frame_sync_monitor_alarm;
    lock_d_r <= secondary_pll_locked;
    phase_monitor_alarm_d_r <= phase_monitor_alarm;
    los_d_r <= los_live;
    if (rst) begin
      primed_r <= 1'b0;
    end else begin
      primed_r <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < `TSEL_NUM_INPUTS; gi = gi + 1) begin : g_in
      assign input_change[gi] = primed_r & ((valid_live[gi] ^ valid_d_r[gi]) |
        (soft_alarm_enable & (input_soft_alarm[gi] ^ soft_d_r[gi])));
    end
  endgenerate

  assign state_change = primed_r & (primary_pll_state_code != state_d_r);
  assign ref_fail_set = selected_ref_failed &
    (primary_pll_state_code != `TSEL_ST_FREE_RUN) & (primary_pll_state_code != `TSEL_ST_HOLDOVER);
  assign frame_sync_monitor_alarm_set = primed_r & frame_sync_monitor_alarm & ~frame_sync_monitor_alarm_d_r;
  assign lock_set = primed_r & (secondary_pll_locked ^ lock_d_r);
  assign phase_monitor_alarm_set = primed_r & phase_monitor_alarm & ~phase_monitor_alarm_d_r;

  tsel_cc_mon #(.LOS_CYCLES(LOS_CYCLES)) u_cc_one (
    .clk(clk),
    .rst(rst),
    .pos_pin(cc_one_pos),
    .neg_pin(cc_one_neg),
    .tone_detect(cc_one_tone),
    .ami_viol_r(ami_pulse[0]),
    .los_r(los_live[0])
  );

  tsel_cc_mon #(.LOS_CYCLES(LOS_CYCLES)) u_cc_two (
    .clk(clk),
    .rst(rst),
    .pos_pin(cc_two_pos),
    .neg_pin(cc_two_neg),
    .tone_detect(cc_two_tone),
    .ami_viol_r(ami_pulse[1]),
    .los_r(los_live[1])
  );

  assign cc_enabled = {~input_two_format_select, ~input_one_format_select};
  assign ami_set = ami_pulse & cc_enabled;
  // Loss flags only on a fresh valid-to-loss transition
  assign los_set = los_live & ~los_d_r & cc_enabled;

  assign wr_a = host_wr & (host_addr == `TSEL_ADDR_FLAGS_A);
  assign wr_b = host_wr & (host_addr == `TSEL_ADDR_FLAGS_B);
  assign wr_c = host_wr & (host_addr == `TSEL_ADDR_FLAGS_C);

  // Clear first, then set, so an event in the clearing cycle is kept.
  // Writes of 0 clear nothing.
  always @* begin
    flags_a_nxt = flags_a_r & ~({8{wr_a}} & host_wdata);
    flags_a_nxt = flags_a_nxt | input_change[`TSEL_NUM_LOW-1:0];

    flags_b_nxt = flags_b_r & ~({8{wr_b}} & host_wdata);
    flags_b_nxt[`TSEL_B_IN_MSB:0] = flags_b_nxt[`TSEL_B_IN_MSB:0] |
      input_change[`TSEL_NUM_INPUTS-1:`TSEL_NUM_LOW];
    flags_b_nxt[`TSEL_B_STATE] = flags_b_nxt[`TSEL_B_STATE] | state_change;
    flags_b_nxt[`TSEL_B_SELECTED_REF_FAILED] = flags_b_nxt[`TSEL_B_SELECTED_REF_FAILED] | ref_fail_set;

    flags_c_nxt = flags_c_r & ~({8{wr_c}} & host_wdata);
    flags_c_nxt[`TSEL_C_FRAME_SYNC_MONITOR_ALARM] = flags_c_nxt[`TSEL_C_FRAME_SYNC_MONITOR_ALARM] | frame_sync_monitor_alarm_set;
    flags_c_nxt[`TSEL_C_LOCK] = flags_c_nxt[`TSEL_C_LOCK] | lock_set;
    flags_c_nxt[`TSEL_C_PHASE_MONITOR_ALARM] = flags_c_nxt[`TSEL_C_PHASE_MONITOR_ALARM] | phase_monitor_alarm_set;
    // Level set: a clear cannot stick while the condition holds
    flags_c_nxt[`TSEL_C_NOIN] = flags_c_nxt[`TSEL_C_NOIN] | secondary_pll_no_input;
    flags_c_nxt[`TSEL_C_BIPOLAR_VIOLATION_IN_TWO] = flags_c_nxt[`TSEL_C_BIPOLAR_VIOLATION_IN_TWO] | ami_set[1];
    flags_c_nxt[`TSEL_C_SIGNAL_LOSS_IN_TWO] = flags_c_nxt[`TSEL_C_SIGNAL_LOSS_IN_TWO] | los_set[1];
    flags_c_nxt[`TSEL_C_BIPOLAR_VIOLATION_IN_ONE] = flags_c_nxt[`TSEL_C_BIPOLAR_VIOLATION_IN_ONE] | ami_set[0];
    flags_c_nxt[`TSEL_C_SIGNAL_LOSS_IN_ONE] = flags_c_nxt[`TSEL_C_SIGNAL_LOSS_IN_ONE] | los_set[0];
  end

  always @(posedge clk) begin
    if (rst) begin
      flags_a_r <= `TSEL_RST_FLAGS_A;
      flags_b_r <= `TSEL_RST_FLAGS_B;
      flags_c_r <= `TSEL_RST_FLAGS_C;
    end else begin
      flags_a_r <= flags_a_nxt;
      flags_b_r <= flags_b_nxt;
      flags_c_r <= flags_c_nxt;
    end
  end

  // Registered request: follows the flags and enables one cycle later
  assign irq_nxt = |({flags_c_r, flags_b_r, flags_a_r} & {irq_enable_c, irq_enable_b, irq_enable_a});

  always @(posedge clk) begin
    if (rst) begin
      interrupt_request_pin <= 1'b0;
    end else begin
      interrupt_request_pin <= irq_nxt;
    end
  end

  assign op_state_view = {frame_sync_monitor_alarm, secondary_pll_locked, primary_soft_alarm,
    secondary_soft_alarm, 1'b0, primary_pll_state_code};
  assign pll_frequency_value_high_view = {5'h00, pll_frequency_value[`TSEL_PLL_FREQUENCY_VALUE_MSB:`TSEL_PLL_FREQUENCY_VALUE_LSB]};

  // Read-only registers have no write path at all
  always @* begin
    case (host_addr)
      `TSEL_ADDR_FLAGS_A: rdata_nxt = flags_a_r;
      `TSEL_ADDR_FLAGS_B: rdata_nxt = flags_b_r;
      `TSEL_ADDR_PLL_FREQUENCY_VALUE_HIGH: rdata_nxt = pll_frequency_value_high_view;
      `TSEL_ADDR_FLAGS_C: rdata_nxt = flags_c_r;
      `TSEL_ADDR_OP_STATE: rdata_nxt = op_state_view;
      default: rdata_nxt = `TSEL_RDATA_IDLE;
    endcase
  end

  always @(posedge clk) begin
    if (rst) begin
      host_rdata_r <= `TSEL_RDATA_IDLE;
    end else if (host_rd) begin
      host_rdata_r <= rdata_nxt;
    end
  end
endmodule // tsel_top
`default_nettype wire

//--- sim/tsel_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module tsel_monitor (
  input wire clk, // Clock
  input wire rst, // Reset
  input wire [7:0] host_addr, // Address
  input wire host_rd, // Read strobe
  input wire host_wr, // Write strobe
  input wire [7:0] host_rdata_r, // Read data
  input wire [7:0] input_valid_live_low, // Validity 1..8
  input wire [2:0] primary_pll_state_code, // State code
  input wire frame_sync_monitor_alarm, // Frame sync alarm
  input wire secondary_pll_locked, // Lock
  input wire primary_soft_alarm, // Primary soft
  input wire secondary_soft_alarm, // Secondary soft
  input wire secondary_pll_no_input, // No input
  input wire [18:0] pll_frequency_value, // Frequency
  input wire [7:0] irq_enable_a, // Enables A
  input wire [7:0] irq_enable_b, // Enables B
  input wire [7:0] irq_enable_c, // Enables C
  input wire interrupt_request_pin // Request
);
  reg [7:0] pll_frequency_value_q;
  reg [7:0] op_q;
  // Live values at the read edge are what the read must return
  always @(posedge clk) begin
    pll_frequency_value_q <= {5'h00, pll_frequency_value[18:16]};
    op_q <= {frame_sync_monitor_alarm, secondary_pll_locked, primary_soft_alarm, secondary_soft_alarm, 1'b0,
      primary_pll_state_code};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property (disable iff (1'b0)
    rst |=> host_rdata_r == 8'h00 && !interrupt_request_pin) else $error("outputs busy after reset");
  a_pll_frequency_value_read: assert property (host_rd && host_addr == 8'h07 |=> host_rdata_r == pll_frequency_value_q)
    else $error("frequency read wrong");
  a_state_read: assert property (host_rd && host_addr == 8'h09 |=> host_rdata_r == op_q)
    else $error("state read wrong");
  a_unmapped_zero: assert property (
    host_rd && (host_addr < 8'h05 || host_addr > 8'h09) |=> host_rdata_r == 8'h00) else $error("unmapped read");
  a_rdata_holds: assert property (!host_rd |=> $stable(host_rdata_r))
    else $error("read data moved");
  a_irq_masked: assert property (
    (irq_enable_a == 8'h00 && irq_enable_b == 8'h00 && irq_enable_c == 8'h00) [*2] |=> !interrupt_request_pin)
    else $error("request while masked");
  a_change_irq: assert property (
    !$past(rst) && $changed(input_valid_live_low) && irq_enable_a == 8'hFF
    |-> ##[1:3] (interrupt_request_pin || irq_enable_a != 8'hFF || host_wr)) else $error("change lost");
  a_noin_irq: assert property ((secondary_pll_no_input && irq_enable_c[4]) [*3] |-> interrupt_request_pin)
    else $error("no-input request missing");
  c_read_c: cover property (host_rd && host_addr == 8'h08);
  c_irq_rise: cover property ($rose(interrupt_request_pin));
  c_noin: cover property (secondary_pll_no_input && irq_enable_c[4]);
endmodule // tsel_monitor
bind tsel_top tsel_monitor mon_u (.clk(clk), .rst(rst), .host_addr(host_addr), .host_rd(host_rd),
  .host_wr(host_wr), .host_rdata_r(host_rdata_r), .input_valid_live_low(input_valid_live_low),
  .primary_pll_state_code(primary_pll_state_code), .frame_sync_monitor_alarm(frame_sync_monitor_alarm),
  .secondary_pll_locked(secondary_pll_locked), .primary_soft_alarm(primary_soft_alarm),
  .secondary_soft_alarm(secondary_soft_alarm), .secondary_pll_no_input(secondary_pll_no_input),
  .pll_frequency_value(pll_frequency_value), .irq_enable_a(irq_enable_a), .irq_enable_b(irq_enable_b),
  .irq_enable_c(irq_enable_c), .interrupt_request_pin(interrupt_request_pin));
`default_nettype wire

//--- sim/tb_tsel_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_tsel_top;
  localparam LOS_N = 50;
  logic clk = 0, rst = 1, host_wr = 0, host_rd = 0, soft_alarm_enable = 0, selected_ref_failed = 0;
  logic frame_sync_monitor_alarm = 0, secondary_pll_locked = 0, primary_soft_alarm = 0, secondary_soft_alarm = 0;
  logic phase_monitor_alarm = 0, secondary_pll_no_input = 0, cc_one_pos = 0, cc_one_neg = 0, cc_two_pos = 0;
  logic cc_two_neg = 0, cc_one_tone = 1, cc_two_tone = 1, input_one_format_select = 0, input_two_format_select = 1;
  logic [7:0] host_addr = 0, host_wdata = 0, input_valid_live_low = 0, irq_enable_a = 0, irq_enable_b = 0;
  logic [7:0] irq_enable_c = 0, fa, w;
  logic [5:0] input_valid_live_high = 0, fb;
  logic [13:0] input_soft_alarm = 0, m, s;
  logic [2:0] primary_pll_state_code = 3'h1;
  logic [2:0] codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [18:0] pll_frequency_value = 0;
  logic [31:0] seed = 32'hB0A91612, r;
  wire [7:0] host_rdata_r;
  wire interrupt_request_pin;
  int fail_count = 0, n_compared = 0;
  tsel_top #(.LOS_CYCLES(LOS_N)) dut_u (.clk(clk), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_r(host_rdata_r),
    .input_valid_live_low(input_valid_live_low), .input_valid_live_high(input_valid_live_high),
    .input_soft_alarm(input_soft_alarm), .soft_alarm_enable(soft_alarm_enable),
    .primary_pll_state_code(primary_pll_state_code), .selected_ref_failed(selected_ref_failed),
    .frame_sync_monitor_alarm(frame_sync_monitor_alarm), .secondary_pll_locked(secondary_pll_locked),
    .primary_soft_alarm(primary_soft_alarm), .secondary_soft_alarm(secondary_soft_alarm),
    .phase_monitor_alarm(phase_monitor_alarm), .secondary_pll_no_input(secondary_pll_no_input),
    .pll_frequency_value(pll_frequency_value), .cc_one_pos(cc_one_pos), .cc_one_neg(cc_one_neg),
    .cc_two_pos(cc_two_pos), .cc_two_neg(cc_two_neg), .cc_one_tone(cc_one_tone), .cc_two_tone(cc_two_tone),
    .input_one_format_select(input_one_format_select), .input_two_format_select(input_two_format_select),
    .irq_enable_a(irq_enable_a), .irq_enable_b(irq_enable_b), .irq_enable_c(irq_enable_c),
    .interrupt_request_pin(interrupt_request_pin));
  initial forever #12.5 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference failure counts everywhere but free-run and holdover
  function automatic logic [7:0] exp_state_b(input logic [2:0] c);
    return {1'b1, (c != 3'h1) && (c != 3'h2), 6'h00};
  endfunction
  function automatic logic exp_irq(input logic [7:0] a, input logic [7:0] ea, input logic [5:0] b,
    input logic [7:0] eb);
    return |{a & ea, b & eb[5:0]};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    host_wr = 1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk);
    host_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    host_rd = 1;
    host_addr = a;
    @(negedge clk);
    host_rd = 0;
    `CHK(host_rdata_r, e)
  endtask
  // Plain alternating marks: no violation anywhere, so every period breaks the pattern
  task automatic mark(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      {cc_one_pos, cc_one_neg} = i[0] ? 2'h1 : 2'h2;
      {cc_two_pos, cc_two_neg} = {cc_one_pos, cc_one_neg};
      tick(2);
      {cc_one_pos, cc_one_neg, cc_two_pos, cc_two_neg} = 4'h0;
      tick(3);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    test_done();
  end
  initial begin
    repeat (4) @(negedge clk);
    rst = 0;
    // Marks start at once so loss of signal cannot fire before traffic
    mark(24);
    rd(8'h08, 8'h50);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    cc_one_tone = 0;
    cc_two_tone = 0;
    mark(24);
    tick(8);
    rd(8'h08, 8'h02);
    tick(LOS_N + 10);
    rd(8'h08, 8'h03);
    `CHK(host_rdata_r[3:2], 2'h0)
    wr(8'h08, 8'h05);
    rd(8'h08, 8'h02);
    wr(8'h08, 8'hFF);
    // Input two joins; fresh marks end both losses, so the next losses are new
    input_two_format_select = 0;
    mark(16);
    tick(LOS_N + 10);
    rd(8'h08, 8'h0F);
    wr(8'h08, 8'hFF);
    $display("composite clock done");
    irq_enable_c = 8'h10;
    {frame_sync_monitor_alarm, secondary_pll_locked, phase_monitor_alarm, secondary_pll_no_input} = 4'hF;
    tick(3);
    rd(8'h08, 8'hF0);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h10);
    `CHK(interrupt_request_pin, 1'b1)
    {frame_sync_monitor_alarm, secondary_pll_locked, phase_monitor_alarm, secondary_pll_no_input} = 4'h0;
    tick(3);
    rd(8'h08, 8'h50);
    wr(8'h08, 8'hFF);
    rd(8'h08, 8'h00);
    `CHK(interrupt_request_pin, 1'b0)
    irq_enable_c = 8'h00;
    $display("status c done");
    primary_pll_state_code = 3'h7;
    tick(2);
    wr(8'h06, 8'hFF);
    foreach (codes[i]) begin
      primary_pll_state_code = codes[i];
      tick(2);
      selected_ref_failed = 1;
      tick(1);
      selected_ref_failed = 0;
      tick(2);
      rd(8'h06, exp_state_b(codes[i]));
      wr(8'h06, 8'hC0);
    end
    $display("state and reference done");
    wr(8'h05, 8'hFF);
    fa = 8'h00;
    fb = 6'h00;
    for (int i = 0; i < 12; i++) begin
      r = rnd();
      soft_alarm_enable = r[31];
      tick(1);
      m = r[13:0];
      s = r[27:14];
      irq_enable_a = i == 0 ? 8'hFF : r[7:0] ^ r[15:8];
      irq_enable_b = r[23:16];
      {input_valid_live_high, input_valid_live_low} ^= m;
      input_soft_alarm ^= s;
      pll_frequency_value = r[18:0];
      {primary_soft_alarm, secondary_soft_alarm} = r[29:28];
      fa |= m[7:0] | (soft_alarm_enable ? s[7:0] : 8'h00);
      fb |= m[13:8] | (soft_alarm_enable ? s[13:8] : 6'h00);
      tick(3);
      `CHK(interrupt_request_pin, exp_irq(fa, irq_enable_a, fb, irq_enable_b))
      rd(8'h05, fa);
      rd(8'h06, {2'h0, fb});
      rd(8'h07, {5'h00, r[18:16]});
      rd(8'h09, {2'h0, r[29:28], 1'b0, primary_pll_state_code});
      w = r[30:23];
      wr(8'h05, w);
      fa &= ~w;
      wr(8'h06, w);
      fb &= ~w[5:0];
      wr(8'h07, w);
      wr(8'h0A, w);
    end
    rd(8'h0A, 8'h00);
    $display("input changes done");
    test_done();
  end
endmodule // tb_tsel_top
`default_nettype wire
